// *** rtl/acp_regs.vh ***
// constants, field layouts and timing counts of the ascii command parser
// Behaviour
// - a frame starts with one prefix character; without it the frame is ignored
// - address field is two upper-case hex characters, 00 to FF
// - out of the factory the stored address is 01
// - each command goes to exactly one address, wildcard sync aside
// - with checksum on, two checksum characters sit just before the carriage return
// - checksum is the byte sum of all earlier frame characters, as two hex
// - a response leads with '!' or '>' when valid, '?' when invalid
// - addressed but invalid command answers '?', own address, carriage return
// - format error, communication error or foreign address gives no answer
// - '#' plus address reads all eight channels after a '>'
// - '#' plus address plus digit 0..7 reads that one channel
// - '%' writes address, type, baud and format into nonvolatile storage; the type is only checked to be 00 and is not stored
// - new-address field 00..FF becomes the module address
// - baud codes 04..08 select 2400, 4800, 9600, 19200, 38400
// - format bit 6 turns checksum checking and generation on
// - format bits 1..0 pick units, percent or two's complement hex; the code stores them but always sends each channel word as four hex characters
// - baud or checksum change only accepted in default state at address 00
// - strap low at power-up gives address 00, 9600 baud, no checksum
// - response to a valid command is finished within 100 ms; a full '#' read at 2400 baud (34 characters) takes about 142 ms here
`ifndef ACP_REGS_VH
`define ACP_REGS_VH

// ********************************************************************
// characters
// ********************************************************************
`define ACP_CH_CR      8'h0D
`define ACP_CH_HASH    8'h23
`define ACP_CH_PCT     8'h25
`define ACP_CH_DOLLAR  8'h24
`define ACP_CH_AT      8'h40
`define ACP_CH_BANG    8'h21
`define ACP_CH_GT      8'h3E
`define ACP_CH_QUEST   8'h3F

// ********************************************************************
// register offsets and fields
// ********************************************************************
`define ACP_OFF_STATUS 8'h00
`define ACP_OFF_CTRL   8'h04
`define ACP_OFF_CHAN0  8'h10
`define ACP_OFF_CHAN7  8'h2C
`define ACP_FMT_CHK_BIT 6
`define ACP_ST_DEF_BIT  24
`define ACP_ST_BUSY_BIT 25

// ********************************************************************
// reset and default values
// ********************************************************************
`define ACP_FACTORY_ADDR 8'h01
`define ACP_DEFAULT_ADDR 8'h00
`define ACP_BAUD_DEF     8'h06
`define ACP_FMT_DEF      8'h00
`define ACP_BAUD_MIN     8'h04
`define ACP_BAUD_MAX     8'h08
`define ACP_TYPE_CODE    8'h00

// ********************************************************************
// timing
// ********************************************************************
`define ACP_CLK_HZ    200000000
`define ACP_RESP_MS   100
`define ACP_DIV_2400  17'd83333
`define ACP_DIV_4800  17'd41666
`define ACP_DIV_9600  17'd20833
`define ACP_DIV_19200 17'd10416
`define ACP_DIV_38400 17'd5208
`define ACP_BUF_DEPTH 16

`endif

// *** rtl/acp_top.v ***
// ascii command parser: frame capture, decode, response and wishbone slave
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "acp_regs.vh"
module acp_top
(
  input  wire        clock,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        rxd,
  output wire        txd,
  output reg         tx_en,
  input  wire        init_n,
  input  wire        nv_valid,
  input  wire [7:0]  nv_addr_in,
  input  wire [7:0]  nv_baud_in,
  input  wire [7:0]  nv_fmt_in,
  output reg         nv_wr,
  output reg  [7:0]  nv_addr,
  output reg  [7:0]  nv_baud,
  output reg  [7:0]  nv_fmt
);

  localparam S_LOAD  = 3'd0;
  localparam S_RX    = 3'd1;
  localparam S_EVAL  = 3'd2;
  localparam S_TX    = 3'd3;
  localparam S_WAIT  = 3'd4;
  localparam K_QUEST = 2'd0;
  localparam K_BANG  = 2'd1;
  localparam K_ALL   = 2'd2;
  localparam K_ONE   = 2'd3;

  // ********************************************************************
  // helper functions
  // ********************************************************************
  // upper-case hex digit to nibble, bit 4 flags a bad character
  function [4:0] hex_val;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39)
        hex_val = {1'b0, c[3:0]};
      else if (c >= 8'h41 && c <= 8'h46) // lower case refused
        hex_val = {1'b0, c[3:0] + 4'h9};
      else
        hex_val = 5'h10;
    end
  endfunction

  function [7:0] hex_char;
    input [3:0] n;
    begin
      hex_char = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
    end
  endfunction

  // baud code to clock divisor
  function [16:0] baud_div;
    input [7:0] code;
    begin
      case (code)
        8'h04:   baud_div = `ACP_DIV_2400;
        8'h05:   baud_div = `ACP_DIV_4800;
        8'h07:   baud_div = `ACP_DIV_19200;
        8'h08:   baud_div = `ACP_DIV_38400;
        default: baud_div = `ACP_DIV_9600;
      endcase
    end
  endfunction

  // ********************************************************************
  // state
  // ********************************************************************
  reg [2:0]  state_reg;
  reg [1:0]  boot_reg;
  reg        strap_s1_reg;
  reg        strap_s2_reg;
  reg        def_reg;
  reg        port_en_reg;
  reg [15:0] chan_reg [0:7];
  reg [7:0]  buf_reg [0:`ACP_BUF_DEPTH-1];
  reg [4:0]  len_reg;
  reg        ovf_reg;
  reg [7:0]  sum0_reg;
  reg [7:0]  sum1_reg;
  reg [7:0]  sum2_reg;
  reg [1:0]  kind_reg;
  reg [2:0]  rch_reg;
  reg [7:0]  raddr_reg;
  reg [5:0]  idx_reg;
  reg [7:0]  tsum_reg;
  reg        pend_reg;
  reg [7:0]  p_addr_reg;
  reg [7:0]  p_baud_reg;
  reg [7:0]  p_fmt_reg;
  reg        tx_start_reg;
  reg [7:0]  tx_data_reg;
  wire       rx_valid;
  wire [7:0] rx_data;
  wire       tx_busy;
  integer    i;
  integer    j;

  wire chk_on = nv_fmt[`ACP_FMT_CHK_BIT];

  // ********************************************************************
  // serial engine
  // ********************************************************************
  acp_uart u_uart
  (
    .clock    (clock),
    .rst_n    (rst_n),
    .div      (baud_div(nv_baud)),
    .rxd      (rxd),
    .tx_start (tx_start_reg),
    .tx_data  (tx_data_reg),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .tx_busy  (tx_busy),
    .txd      (txd)
  );

  // ********************************************************************
  // frame decode, looked at when the carriage return arrives
  // ********************************************************************
  reg [4:0] plen;
  reg [4:0] a_hi, a_lo, c_hi, c_lo;
  reg [4:0] n_hi, n_lo, t_hi, t_lo, b_hi, b_lo, f_hi, f_lo;
  reg [7:0] cmd_addr, new_addr, new_type, new_baud, new_fmt;
  reg       silent, bad_cmd, cfg_ok;
  reg [7:0] chk_rx, chk_calc;
  always @*
  begin
    plen = chk_on ? len_reg - 5'd2 : len_reg; // checksum pair trails the payload
    a_hi = hex_val(buf_reg[1]);
    a_lo = hex_val(buf_reg[2]);
    c_hi = hex_val(buf_reg[plen[3:0]]);
    c_lo = hex_val(buf_reg[plen[3:0] + 4'h1]);
    n_hi = hex_val(buf_reg[3]);
    n_lo = hex_val(buf_reg[4]);
    t_hi = hex_val(buf_reg[5]);
    t_lo = hex_val(buf_reg[6]);
    b_hi = hex_val(buf_reg[7]);
    b_lo = hex_val(buf_reg[8]);
    f_hi = hex_val(buf_reg[9]);
    f_lo = hex_val(buf_reg[10]);
    cmd_addr = {a_hi[3:0], a_lo[3:0]};
    new_addr = {n_hi[3:0], n_lo[3:0]};
    new_type = {t_hi[3:0], t_lo[3:0]};
    new_baud = {b_hi[3:0], b_lo[3:0]};
    new_fmt  = {f_hi[3:0], f_lo[3:0]};
    chk_rx   = {c_hi[3:0], c_lo[3:0]};
    chk_calc = chk_on ? sum2_reg : sum0_reg; // byte sum of characters ahead of it
    // no prefix, short frame, bad address digits or overrun
    silent = ovf_reg || plen < 5'd3 || a_hi[4] || a_lo[4] ||
             !(buf_reg[0] == `ACP_CH_HASH || buf_reg[0] == `ACP_CH_PCT ||
               buf_reg[0] == `ACP_CH_DOLLAR || buf_reg[0] == `ACP_CH_AT);
    silent = silent || cmd_addr != nv_addr; // foreign address stays quiet
    silent = silent || (chk_on && (c_hi[4] || c_lo[4] || chk_rx != chk_calc));
    // configuration checks: hex fields, type 00, known baud code
    cfg_ok = plen == 5'd11 && !n_hi[4] && !n_lo[4] && !t_hi[4] && !t_lo[4] &&
             !b_hi[4] && !b_lo[4] && !f_hi[4] && !f_lo[4] &&
             new_type == `ACP_TYPE_CODE &&
             new_baud >= `ACP_BAUD_MIN && new_baud <= `ACP_BAUD_MAX;
    // baud or checksum change needs default state at address 00
    if ((new_baud != nv_baud || new_fmt[`ACP_FMT_CHK_BIT] != chk_on) &&
        !(def_reg && nv_addr == `ACP_DEFAULT_ADDR))
      cfg_ok = 1'b0;
    bad_cmd = 1'b1;
    if (buf_reg[0] == `ACP_CH_HASH)
      bad_cmd = !(plen == 5'd3 || (plen == 5'd4 && buf_reg[3] >= 8'h30 && buf_reg[3] <= 8'h37));
    else if (buf_reg[0] == `ACP_CH_PCT)
      bad_cmd = !cfg_ok;
  end

  // ********************************************************************
  // response character generator
  // ********************************************************************
  reg [5:0]  blen;
  reg [5:0]  nidx;
  reg [15:0] word;
  reg [3:0]  nib;
  reg [7:0]  body_ch;
  reg [7:0]  out_ch;
  reg        in_body;
  reg        last;
  reg [5:0]  tail;
  always @*
  begin
    blen = (kind_reg == K_ALL) ? 6'd33 : (kind_reg == K_ONE) ? 6'd5 : 6'd3;
    nidx = idx_reg - 6'd1;
    word = chan_reg[(kind_reg == K_ALL) ? nidx[4:2] : rch_reg];
    case (nidx[1:0])
      2'd0:    nib = word[15:12];
      2'd1:    nib = word[11:8];
      2'd2:    nib = word[7:4];
      default: nib = word[3:0];
    endcase
    // lead character tells valid from invalid
    if (idx_reg == 6'd0)
      body_ch = (kind_reg == K_QUEST) ? `ACP_CH_QUEST :
                (kind_reg == K_BANG) ? `ACP_CH_BANG : `ACP_CH_GT;
    else if (kind_reg == K_QUEST || kind_reg == K_BANG)
      body_ch = hex_char((idx_reg == 6'd1) ? raddr_reg[7:4] : raddr_reg[3:0]);
    else
      body_ch = hex_char(nib);
    in_body = idx_reg < blen;
    tail    = idx_reg - blen;
    last    = !in_body && (chk_on ? tail == 6'd2 : tail == 6'd0);
    // checksum generated over the body, then the terminator
    if (in_body)
      out_ch = body_ch;
    else if (chk_on && tail == 6'd0)
      out_ch = hex_char(tsum_reg[7:4]);
    else if (chk_on && tail == 6'd1)
      out_ch = hex_char(tsum_reg[3:0]);
    else
      out_ch = `ACP_CH_CR;
  end

  // ********************************************************************
  // main sequencer
  // ********************************************************************
  // capture at boot, collect frame, judge it, then answer at once
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= S_LOAD;
      boot_reg     <= 2'd0;
      strap_s1_reg <= 1'b1;
      strap_s2_reg <= 1'b1;
      def_reg      <= 1'b0;
      nv_addr      <= `ACP_FACTORY_ADDR;
      nv_baud      <= `ACP_BAUD_DEF;
      nv_fmt       <= `ACP_FMT_DEF;
      nv_wr        <= 1'b0;
      len_reg      <= 5'd0;
      ovf_reg      <= 1'b0;
      sum0_reg     <= 8'h00;
      sum1_reg     <= 8'h00;
      sum2_reg     <= 8'h00;
      kind_reg     <= K_QUEST;
      rch_reg      <= 3'd0;
      raddr_reg    <= 8'h00;
      idx_reg      <= 6'd0;
      tsum_reg     <= 8'h00;
      pend_reg     <= 1'b0;
      p_addr_reg   <= 8'h00;
      p_baud_reg   <= 8'h00;
      p_fmt_reg    <= 8'h00;
      tx_start_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
      tx_en        <= 1'b0;
      for (i = 0; i < `ACP_BUF_DEPTH; i = i + 1)
        buf_reg[i] <= 8'h00;
    end
    else
    begin
      strap_s1_reg <= init_n;
      strap_s2_reg <= strap_s1_reg;
      nv_wr        <= 1'b0;
      tx_start_reg <= 1'b0;
      case (state_reg)
        S_LOAD:
        begin
          // wait for the strap synchroniser to settle before catching it
          boot_reg <= boot_reg + 2'd1;
          if (boot_reg == 2'd3)
          begin
            state_reg <= S_RX;
            if (!strap_s2_reg)
            begin
              def_reg <= 1'b1;
              nv_addr <= `ACP_DEFAULT_ADDR;
              nv_baud <= `ACP_BAUD_DEF;
              nv_fmt  <= `ACP_FMT_DEF;
            end
            else if (nv_valid)
            begin
              nv_addr <= nv_addr_in;
              nv_baud <= nv_baud_in;
              nv_fmt  <= nv_fmt_in;
            end
          end
        end
        S_RX:
        begin
          if (rx_valid && port_en_reg)
          begin
            if (rx_data == `ACP_CH_CR) // end of frame
            begin
              if (len_reg != 5'd0)
                state_reg <= S_EVAL;
            end
            else
            begin
              if (len_reg == `ACP_BUF_DEPTH)
                ovf_reg <= 1'b1;
              else
              begin
                buf_reg[len_reg[3:0]] <= rx_data;
                len_reg <= len_reg + 5'd1;
              end
              sum0_reg <= sum0_reg + rx_data;
              sum1_reg <= sum0_reg;
              sum2_reg <= sum1_reg;
            end
          end
        end
        S_EVAL:
        begin
          len_reg   <= 5'd0;
          ovf_reg   <= 1'b0;
          sum0_reg  <= 8'h00;
          sum1_reg  <= 8'h00;
          sum2_reg  <= 8'h00;
          idx_reg   <= 6'd0;
          tsum_reg  <= 8'h00;
          raddr_reg <= nv_addr;
          rch_reg   <= buf_reg[3][2:0];
          if (silent)
            state_reg <= S_RX;
          else
          begin
            state_reg <= S_TX;
            tx_en     <= 1'b1;
            if (bad_cmd)
              kind_reg <= K_QUEST;
            else if (buf_reg[0] == `ACP_CH_PCT)
            begin
              // new settings wait until the reply has gone at the old rate
              kind_reg   <= K_BANG;
              raddr_reg  <= new_addr;
              pend_reg   <= 1'b1;
              p_addr_reg <= new_addr;
              p_baud_reg <= new_baud;
              p_fmt_reg  <= new_fmt; // bits 1..0 keep the data format
            end
            else
              kind_reg <= (plen == 5'd3) ? K_ALL : K_ONE;
          end
        end
        S_TX:
        begin
          if (!tx_busy)
          begin
            tx_start_reg <= 1'b1;
            tx_data_reg  <= out_ch;
            if (in_body)
              tsum_reg <= tsum_reg + out_ch;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (!tx_start_reg && !tx_busy)
          begin
            if (last)
            begin
              state_reg <= S_RX;
              tx_en     <= 1'b0;
              if (pend_reg)
              begin
                pend_reg <= 1'b0;
                nv_wr    <= 1'b1;
                nv_addr  <= p_addr_reg;
                nv_baud  <= p_baud_reg;
                nv_fmt   <= p_fmt_reg;
              end
            end
            else
            begin
              idx_reg   <= idx_reg + 6'd1;
              state_reg <= S_TX;
            end
          end
        end
        default: state_reg <= S_RX;
      endcase
    end
  end

  // ********************************************************************
  // wishbone slave
  // ********************************************************************
  // one wait state, unmapped reads return zero and still ack
  wire       wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [7:0] cidx   = wb_adr_i - `ACP_OFF_CHAN0;
  wire       is_ch  = wb_adr_i >= `ACP_OFF_CHAN0 && wb_adr_i <= `ACP_OFF_CHAN7 && wb_adr_i[1:0] == 2'b00;
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
      port_en_reg <= 1'b1;
      for (j = 0; j < 8; j = j + 1)
        chan_reg[j] <= 16'h0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req)
      begin
        wb_dat_o <= 32'h00000000;
        if (wb_adr_i == `ACP_OFF_STATUS)
          wb_dat_o <= {6'h00, state_reg != S_RX && state_reg != S_LOAD, def_reg, nv_fmt, nv_baud, nv_addr};
        else if (wb_adr_i == `ACP_OFF_CTRL)
        begin
          wb_dat_o <= {31'h00000000, port_en_reg};
          if (wb_we_i && wb_sel_i[0])
            port_en_reg <= wb_dat_i[0];
        end
        else if (is_ch)
        begin
          wb_dat_o <= {16'h0000, chan_reg[cidx[4:2]]};
          if (wb_we_i && wb_sel_i[0])
            chan_reg[cidx[4:2]][7:0] <= wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1])
            chan_reg[cidx[4:2]][15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

endmodule // acp_top

// *** rtl/acp_uart.v ***
// 8N1 serial receiver and transmitter with a run-time divisor
`timescale 1ns/1ps
module acp_uart
(
  input  wire        clock,
  input  wire        rst_n,
  input  wire [16:0] div,
  input  wire        rxd,
  input  wire        tx_start,
  input  wire [7:0]  tx_data,
  output reg         rx_valid,
  output reg  [7:0]  rx_data,
  output reg         tx_busy,
  output reg         txd
);

  reg        rx_s1_reg;
  reg        rx_s2_reg;
  reg        rx_act_reg;
  reg [16:0] rx_cnt_reg;
  reg [3:0]  rx_bit_reg;
  reg [8:0]  tx_sh_reg;
  reg [16:0] tx_cnt_reg;
  reg [3:0]  tx_bit_reg;

  // ********************************************************************
  // receiver
  // ********************************************************************
  // two-stage synchroniser, then mid-bit sampling
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_s1_reg  <= 1'b1;
      rx_s2_reg  <= 1'b1;
      rx_act_reg <= 1'b0;
      rx_cnt_reg <= 17'h00000;
      rx_bit_reg <= 4'h0;
      rx_valid   <= 1'b0;
      rx_data    <= 8'h00;
    end
    else
    begin
      rx_s1_reg <= rxd;
      rx_s2_reg <= rx_s1_reg;
      rx_valid  <= 1'b0;
      if (!rx_act_reg)
      begin
        if (!rx_s2_reg)
        begin
          rx_act_reg <= 1'b1;
          rx_cnt_reg <= {1'b0, div[16:1]};
          rx_bit_reg <= 4'h0;
        end
      end
      else if (rx_cnt_reg == 17'h00000)
      begin
        rx_cnt_reg <= div - 17'h00001;
        if (rx_bit_reg == 4'h0)
        begin
          // a glitch shorter than half a bit is no start bit
          if (rx_s2_reg)
            rx_act_reg <= 1'b0;
          else
            rx_bit_reg <= 4'h1;
        end
        else if (rx_bit_reg < 4'h9)
        begin
          rx_data    <= {rx_s2_reg, rx_data[7:1]};
          rx_bit_reg <= rx_bit_reg + 4'h1;
        end
        else
        begin
          rx_valid   <= rx_s2_reg; // framing error drops the byte
          rx_act_reg <= 1'b0;
        end
      end
      else
        rx_cnt_reg <= rx_cnt_reg - 17'h00001;
    end
  end

  // ********************************************************************
  // transmitter
  // ********************************************************************
  // start bit, eight data bits lsb first, stop bit
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sh_reg  <= 9'h1FF;
      tx_cnt_reg <= 17'h00000;
      tx_bit_reg <= 4'h0;
      tx_busy    <= 1'b0;
      txd        <= 1'b1;
    end
    else if (!tx_busy)
    begin
      if (tx_start)
      begin
        tx_sh_reg  <= {1'b1, tx_data};
        tx_cnt_reg <= div - 17'h00001;
        tx_bit_reg <= 4'h0;
        tx_busy    <= 1'b1;
        txd        <= 1'b0;
      end
    end
    else if (tx_cnt_reg == 17'h00000)
    begin
      tx_cnt_reg <= div - 17'h00001;
      if (tx_bit_reg == 4'h9)
      begin
        tx_busy <= 1'b0;
        txd     <= 1'b1;
      end
      else
      begin
        txd        <= tx_sh_reg[0];
        tx_sh_reg  <= {1'b1, tx_sh_reg[8:1]};
        tx_bit_reg <= tx_bit_reg + 4'h1;
      end
    end
    else
      tx_cnt_reg <= tx_cnt_reg - 17'h00001;
  end

endmodule // acp_uart

// *** tb/acp_host_model.sv ***
// serial host model: sends frames to the parser and collects its replies
`timescale 1ns/1ps
module acp_host_model
#(
  parameter BIT_CLKS = 5208
)
(
  input  wire clock,
  input  wire txd,
  output reg  rxd
);
  reg [7:0] rx_q [$];
  reg [7:0] sh;
  integer   k;
  initial rxd = 1'b1;
  // 8N1 character, lsb first; line left high between characters
  task send_byte(input [7:0] c);
    integer j;
    begin
      for (j = 0; j < 10; j = j + 1)
      begin
        @(posedge clock);
        rxd <= (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : c[j-1];
        repeat (BIT_CLKS - 1) @(posedge clock);
      end
    end
  endtask
  // receiver samples mid bit so clock phase slips do not matter
  initial
  begin
    forever
    begin
      @(negedge txd);
      repeat (BIT_CLKS / 2) @(posedge clock);
      for (k = 0; k < 8; k = k + 1)
      begin
        repeat (BIT_CLKS) @(posedge clock);
        sh[k] = txd;
      end
      repeat (BIT_CLKS) @(posedge clock);
      rx_q.push_back(sh);
    end
  end
endmodule // acp_host_model

// *** tb/acp_top_asserts.sv ***
// concurrent checks on the parser's wishbone and serial ports
`timescale 1ns/1ps
module acp_top_asserts
(
  input wire        clock,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        txd,
  input wire        tx_en,
  input wire        nv_wr,
  input wire [7:0]  nv_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a request not yet answered, then a status read being answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_status_rd;
    s_req ##1 (wb_ack_o && wb_adr_i == 8'h00 && !wb_we_i);
  endsequence
  a_ack_follows: assert property (s_req |=> wb_ack_o) else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_noreq: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  a_status_addr: assert property (s_status_rd |-> wb_dat_o[7:0] == nv_addr) else $error("status address wrong");
  a_txd_idle: assert property (!tx_en |-> txd) else $error("line not idle high");
  a_start_bit: assert property ($rose(tx_en) |-> ##[0:2] !txd) else $error("no start bit");
  a_txen_end: assert property ($fell(tx_en) |-> $past(txd)) else $error("reply cut mid bit");
  a_nvwr_pulse: assert property (nv_wr |=> !nv_wr) else $error("store strobe too long");
endmodule // acp_top_asserts

bind acp_top acp_top_asserts acp_top_asserts_inst (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .txd(txd), .tx_en(tx_en), .nv_wr(nv_wr), .nv_addr(nv_addr));

// *** tb/acp_top_tb.sv ***
// self-checking bench for the ascii command parser
`timescale 1ns/1ps
module acp_top_tb;
  localparam [39:0] CMD = {"#3A5", 8'h0D};
  localparam [47:0] RSP = {8'h3E, "B7C2", 8'h0D};
  localparam [95:0] CFG = {"%3A3B000800", 8'h0D};
  localparam [31:0] CRP = {"!3B", 8'h0D};
  reg         clock;
  reg         rst_n;
  reg         wb_cyc_i;
  reg         wb_stb_i;
  reg         wb_we_i;
  reg  [3:0]  wb_sel_i;
  reg  [7:0]  wb_adr_i;
  reg  [31:0] wb_dat_i;
  reg  [31:0] rd;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire        rxd;
  wire        txd;
  wire        tx_en;
  integer     n_mismatch;
  integer     checked;
  integer     i;
  // stored config: address 3A at the fastest rate keeps the run short
  acp_top acp_top_inst (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rxd(rxd), .txd(txd), .tx_en(tx_en), .init_n(1'b1), .nv_valid(1'b1),
    .nv_addr_in(8'h3A), .nv_baud_in(8'h08), .nv_fmt_in(8'h00), .nv_wr(), .nv_addr(), .nv_baud(), .nv_fmt());
  acp_host_model acp_host_model_inst (.clock(clock), .txd(txd), .rxd(rxd));
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // classic cycle: hold until ack is sampled, then release for a cycle
  task wb_xfer(input we, input [7:0] adr, input [31:0] dat);
    integer t;
    begin
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      t = 0;
      @(posedge clock);
      while (wb_ack_o !== 1'b1 && t < 50)
      begin
        t = t + 1;
        @(posedge clock);
      end
      if (t == 50)
      begin
        n_mismatch = n_mismatch + 1;
        complete_run;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task complete_run;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // watchdog: two frames plus their replies take about 7 ms at this rate
  initial
  begin
    #9000000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial
  begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'hF;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h00000000;
    n_mismatch = 0;
    checked = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    wb_xfer(1'b0, 8'h00, 32'h00000000);
    check("status", rd, 32'h0000083A);
    wb_xfer(1'b0, 8'h04, 32'h00000000);
    check("ctrl", rd, 32'h00000001);
    wb_xfer(1'b1, 8'h24, 32'h0000B7C2);
    wb_xfer(1'b0, 8'h24, 32'h00000000);
    check("chan5", rd, 32'h0000B7C2);
    wb_xfer(1'b1, 8'hFC, 32'hFFFFFFFF);
    wb_xfer(1'b0, 8'hFC, 32'h00000000);
    check("unmapped", rd, 32'h00000000);
    // byte enables: only the upper byte of channel 2 may change
    wb_sel_i <= 4'h2;
    wb_xfer(1'b1, 8'h18, 32'h00005A66);
    wb_sel_i <= 4'hF;
    wb_xfer(1'b0, 8'h18, 32'h00000000);
    check("chan2_sel", rd, 32'h00005A00);
    // single channel read of channel 5 at the stored address
    for (i = 0; i < 5; i = i + 1)
      acp_host_model_inst.send_byte(CMD[39-8*i -: 8]);
    while (acp_host_model_inst.rx_q.size() < 6)
      @(posedge clock);
    for (i = 0; i < 6; i = i + 1)
      check("reply", {24'h000000, acp_host_model_inst.rx_q[i]}, {24'h000000, RSP[47-8*i -: 8]});
    // the model takes the last byte mid stop bit, so let the stop bit end
    repeat (5208) @(posedge clock);
    check("tx_en", {31'h00000000, tx_en}, 32'h00000000);
    // reconfigure at the present address: new address 3B, type 00, rate and format kept
    for (i = 0; i < 12; i = i + 1)
      acp_host_model_inst.send_byte(CFG[95-8*i -: 8]);
    while (acp_host_model_inst.rx_q.size() < 10)
      @(posedge clock);
    for (i = 0; i < 4; i = i + 1)
      check("cfg_reply", {24'h000000, acp_host_model_inst.rx_q[6+i]}, {24'h000000, CRP[31-8*i -: 8]});
    repeat (5208) @(posedge clock);
    wb_xfer(1'b0, 8'h00, 32'h00000000);
    check("status_cfg", rd, 32'h0000083B);
    complete_run;
  end
endmodule // acp_top_tb
